// file: logic/card_irq_pkg.sv
// constants and register map of the card interrupt enable block
//
// Function
// - ready rising edge interrupts only when bit 10 set
// - slot 1 change interrupts only when bit 9 set
// - slot 0 change interrupts only when bit 8 set
// - compare computed code with stored spare code
// - code mismatch interrupts only when bit 1 set
// - flags read-only, cleared by writing one
// - slot flag sets only while its enable set
package card_irq_pkg;
    // byte addresses on the apb
    localparam logic [7:0]  OFS_ENABLE     = 8'hA8;
    localparam logic [7:0]  OFS_STATUS     = 8'hAC;
    localparam logic [7:0]  OFS_CLEAR      = 8'hB4;
    localparam logic [7:0]  OFS_ECC_STORED = 8'hB8;
    // field positions shared by enable, status and clear
    localparam int          BIT_ECC        = 1;
    localparam int          BIT_SLOT0      = 8;
    localparam int          BIT_SLOT1      = 9;
    localparam int          BIT_READY      = 10;
    // pin levels in status
    localparam int          BIT_SLOT0_PIN  = 16;
    localparam int          BIT_SLOT1_PIN  = 17;
    localparam int          BIT_READY_PIN  = 18;
    localparam logic [31:0] EVENT_MASK     = 32'h0000_0702;
    localparam logic [31:0] ENABLE_RESET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
    localparam int          ECC_WIDTH      = 24;
endpackage

// file: logic/ecc_compare.sv
// compares the host-computed code with the code held in the spare area
`timescale 1ns/100ps
module ecc_compare
    import card_irq_pkg::*;
#(
    parameter int W = ECC_WIDTH
)(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         check_strobe,
    input  wire logic [W-1:0] ecc_computed,
    input  wire logic [W-1:0] ecc_stored,
    output logic              mismatch_pulse
);
    // one-cycle pulse when codes differ at the end of a read
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mismatch_pulse <= 1'b0;
        else
            mismatch_pulse <= check_strobe && (ecc_computed != ecc_stored);
    end
endmodule // ecc_compare

// file: logic/nand_card_irq_enable.sv
// apb register block holding interrupt enables, event flags and irq output
`timescale 1ns/100ps
module nand_card_irq_enable
    import card_irq_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ready_busy,
    input  wire logic                 slot0_detect,
    input  wire logic                 slot1_detect,
    input  wire logic                 ecc_check,
    input  wire logic [ECC_WIDTH-1:0] ecc_computed,
    output logic                      irq
);
    logic [31:0]          card_irq_enable_r;
    logic [31:0]          card_irq_status_r;
    logic [ECC_WIDTH-1:0] ecc_stored_r;
    logic                 ready_busy_r;
    logic                 slot0_r;
    logic                 slot1_r;
    logic                 ecc_mismatch;
    logic [31:0]          event_set;
    logic [31:0]          clear_mask;
    logic [31:0]          rdata_nxt;
    logic                 wr_access;
    logic                 addr_ok;

    // apb access phase; zero wait, unmapped address answers pslverr
    assign wr_access = psel && penable && pwrite;
    assign addr_ok   = (paddr == OFS_ENABLE) || (paddr == OFS_STATUS)
                    || (paddr == OFS_CLEAR) || (paddr == OFS_ECC_STORED);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;

    ecc_compare #(.W(ECC_WIDTH)) u_cmp (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .check_strobe   (ecc_check),
        .ecc_computed   (ecc_computed),
        .ecc_stored     (ecc_stored_r),
        .mismatch_pulse (ecc_mismatch)
    );

    // previous pin levels for edge detection
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_busy_r <= 1'b1; // idle level of ready, so release gives no false edge
            slot0_r      <= 1'b0;
            slot1_r      <= 1'b0;
        end
        else
        begin
            ready_busy_r <= ready_busy;
            slot0_r      <= slot0_detect;
            slot1_r      <= slot1_detect;
        end
    end

    // enable register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            card_irq_enable_r <= ENABLE_RESET;
        else if (wr_access && paddr == OFS_ENABLE)
            card_irq_enable_r <= pwdata & EVENT_MASK;
    end

    // stored spare-area code loaded by software
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ecc_stored_r <= '0;
        else if (wr_access && paddr == OFS_ECC_STORED)
            ecc_stored_r <= pwdata[ECC_WIDTH-1:0];
    end

    // events, each gated by its enable
    always_comb
    begin
        event_set            = '0;
        event_set[BIT_READY] = ready_busy && !ready_busy_r
                            && card_irq_enable_r[BIT_READY];
        event_set[BIT_SLOT1] = (slot1_detect != slot1_r)
                            && card_irq_enable_r[BIT_SLOT1];
        event_set[BIT_SLOT0] = (slot0_detect != slot0_r)
                            && card_irq_enable_r[BIT_SLOT0];
        event_set[BIT_ECC]   = ecc_mismatch && card_irq_enable_r[BIT_ECC];
    end

    // write one clears, at status or clear offset
    assign clear_mask = (wr_access && (paddr == OFS_STATUS || paddr == OFS_CLEAR))
                      ? (pwdata & EVENT_MASK) : 32'h0000_0000;

    // sticky flags; set wins over clear
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            card_irq_status_r <= STATUS_RESET;
        else
            card_irq_status_r <= (card_irq_status_r & ~clear_mask) | event_set;
    end

    // read data mux, feeds the read data register
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            OFS_ENABLE:
                rdata_nxt = card_irq_enable_r;
            OFS_STATUS:
            begin
                rdata_nxt                = card_irq_status_r;
                rdata_nxt[BIT_READY_PIN] = ready_busy;
                rdata_nxt[BIT_SLOT1_PIN] = slot1_detect;
                rdata_nxt[BIT_SLOT0_PIN] = slot0_detect;
            end
            OFS_ECC_STORED:
                rdata_nxt[ECC_WIDTH-1:0] = ecc_stored_r;
            default:
                rdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data register; loaded in setup so it stands through the access cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= rdata_nxt;
    end

    // level interrupt
    assign irq = |(card_irq_status_r & card_irq_enable_r);

    a_ready_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ready_busy && !ready_busy_r && card_irq_enable_r[BIT_READY])
        |=> card_irq_status_r[BIT_READY])
        else $error("ready edge flag not set");
    a_ready_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!card_irq_status_r[BIT_READY] && !card_irq_enable_r[BIT_READY])
        |=> !card_irq_status_r[BIT_READY])
        else $error("ready flag set while disabled");
    a_slot1_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(card_irq_status_r[BIT_SLOT1])
        |-> $past(card_irq_enable_r[BIT_SLOT1]) && $past(slot1_detect != slot1_r))
        else $error("slot1 flag set without cause");
    a_slot0_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(card_irq_status_r[BIT_SLOT0])
        |-> $past(card_irq_enable_r[BIT_SLOT0]) && $past(slot0_detect != slot0_r))
        else $error("slot0 flag set without cause");
    a_ecc_compare: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ecc_check && ecc_computed != ecc_stored_r) |=> ecc_mismatch)
        else $error("mismatch not detected");
    a_ecc_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ecc_mismatch && card_irq_enable_r[BIT_ECC]) |=> card_irq_status_r[BIT_ECC])
        else $error("ecc flag not set");
    a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clear_mask[BIT_ECC] && !event_set[BIT_ECC])
        |=> !card_irq_status_r[BIT_ECC])
        else $error("write one did not clear");
    a_slot_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!card_irq_enable_r[BIT_SLOT0] && !card_irq_status_r[BIT_SLOT0])
        |=> !card_irq_status_r[BIT_SLOT0])
        else $error("slot0 flag while disabled");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        (card_irq_enable_r[BIT_ECC] && card_irq_status_r[BIT_ECC]) |-> irq)
        else $error("irq low with enabled flag");

    // disabled events leave their flags clear
    a_slot1_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!card_irq_enable_r[BIT_SLOT1] && !card_irq_status_r[BIT_SLOT1])
        |=> !card_irq_status_r[BIT_SLOT1])
        else $error("slot1 flag while disabled");
    a_ecc_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!card_irq_enable_r[BIT_ECC] && !card_irq_status_r[BIT_ECC])
        |=> !card_irq_status_r[BIT_ECC])
        else $error("ecc flag while disabled");

    // code comparison answers only to a check strobe with differing codes
    a_ecc_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ecc_check |=> !ecc_mismatch)
        else $error("mismatch without check");
    a_ecc_equal: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ecc_check && ecc_computed == ecc_stored_r) |=> !ecc_mismatch)
        else $error("mismatch on equal codes");

    // write one clears and otherwise flags stay put
    a_ready_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clear_mask[BIT_READY] && !event_set[BIT_READY])
        |=> !card_irq_status_r[BIT_READY])
        else $error("ready flag not cleared");
    a_slot0_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clear_mask[BIT_SLOT0] && !event_set[BIT_SLOT0])
        |=> !card_irq_status_r[BIT_SLOT0])
        else $error("slot0 flag not cleared");
    a_slot1_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clear_mask[BIT_SLOT1] && !event_set[BIT_SLOT1])
        |=> !card_irq_status_r[BIT_SLOT1])
        else $error("slot1 flag not cleared");
    a_ready_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (card_irq_status_r[BIT_READY] && !clear_mask[BIT_READY])
        |=> card_irq_status_r[BIT_READY])
        else $error("ready flag lost");
    a_ecc_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (card_irq_status_r[BIT_ECC] && !clear_mask[BIT_ECC])
        |=> card_irq_status_r[BIT_ECC])
        else $error("ecc flag lost");

    // enabled flags drive the interrupt line
    a_irq_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
        (card_irq_enable_r[BIT_READY] && card_irq_status_r[BIT_READY]) |-> irq)
        else $error("irq low with ready flag");
    a_irq_slots: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((card_irq_enable_r[BIT_SLOT0] && card_irq_status_r[BIT_SLOT0])
        || (card_irq_enable_r[BIT_SLOT1] && card_irq_status_r[BIT_SLOT1])) |-> irq)
        else $error("irq low with slot flag");

    c_ready_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        event_set[BIT_READY] ##1 irq);
    c_slot1_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        event_set[BIT_SLOT1] ##1 irq);
    c_slot0_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        event_set[BIT_SLOT0] ##1 irq);
    c_ecc_irq:   cover property (@(posedge core_clk) disable iff (!rst_n)
        event_set[BIT_ECC] ##1 irq ##[1:20] !irq);
endmodule // nand_card_irq_enable

// file: bench/nand_card_model.sv
// behavioural nand card: ready/busy line and detect levels of two slots
`timescale 1ns/100ps
module nand_card_model
#(
    parameter int BUSY_CYCLES = 3
)(
    input  wire logic core_clk,
    input  wire logic start_busy,
    input  wire logic card0_in,
    input  wire logic card1_in,
    output logic      ready_busy,
    output logic      slot0_detect,
    output logic      slot1_detect
);
    int busy_cnt = 0;
    // ready line is low for the busy period after a command
    always @(posedge core_clk)
    begin
        if (start_busy)
            busy_cnt <= BUSY_CYCLES;
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
    end
    assign ready_busy   = (busy_cnt == 0);
    assign slot0_detect = card0_in;
    assign slot1_detect = card1_in;
endmodule // nand_card_model

// file: bench/tb.sv
// self-checking bench for the card interrupt enable block
`timescale 1ns/100ps
module tb;
    import card_irq_pkg::*;
    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0;
    logic [31:0]          prdata, rd;
    logic                 pready, pslverr, irq, err;
    logic                 ready_busy, slot0_detect, slot1_detect;
    logic                 ecc_check = 1'b0;
    logic [ECC_WIDTH-1:0] ecc_computed = '0;
    logic                 start_busy = 1'b0;
    logic                 card0 = 1'b0;
    logic                 card1 = 1'b0;
    int                   failures = 0;
    int                   comparisons = 0;
    int                   cycles = 0;
    int                   pos[3] = '{BIT_READY, BIT_SLOT0, BIT_SLOT1};

    always #5 core_clk = ~core_clk;

    nand_card_irq_enable u_nand_card_irq_enable (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ready_busy(ready_busy),
        .slot0_detect(slot0_detect), .slot1_detect(slot1_detect), .ecc_check(ecc_check),
        .ecc_computed(ecc_computed), .irq(irq));
    nand_card_model u_nand_card_model (.core_clk(core_clk), .start_busy(start_busy),
        .card0_in(card0), .card1_in(card1), .ready_busy(ready_busy),
        .slot0_detect(slot0_detect), .slot1_detect(slot1_detect));

    // one apb transfer, entered right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // live pin bits of the status word, ready assumed settled high
    function automatic logic [31:0] pins();
        return 32'h0004_0000 | {14'h0, card1, card0, 16'h0};
    endfunction

    // makes one card event: ready rising edge or a slot change
    task automatic fire(input int k);
        if (k == 0)
            start_busy <= 1'b1;
        else if (k == 1)
            card0 <= ~card0;
        else
            card1 <= ~card1;
        @(posedge core_clk);
        start_busy <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic ecc(input logic [23:0] v);
        ecc_computed <= v;
        ecc_check    <= 1'b1;
        @(posedge core_clk);
        ecc_check <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic end_of_test;
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            end_of_test();
        end
    end

    // main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdc(OFS_ENABLE, ENABLE_RESET);
        rdc(OFS_STATUS, pins());
        apb(1'b1, OFS_ENABLE, 32'hFFFF_FFFF);
        rdc(OFS_ENABLE, EVENT_MASK);
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, OFS_ENABLE, EVENT_MASK & ~(32'h1 << pos[k]));
            fire(k);
            rdc(OFS_STATUS, pins());
            chk({31'h0, irq}, 32'h0);
            apb(1'b1, OFS_ENABLE, 32'h1 << pos[k]);
            fire(k);
            rdc(OFS_STATUS, pins() | (32'h1 << pos[k]));
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, OFS_STATUS, 32'h0);
            rdc(OFS_STATUS, pins() | (32'h1 << pos[k]));
            apb(1'b1, OFS_STATUS, 32'h1 << pos[k]);
            chk({31'h0, irq}, 32'h0);
        end
        apb(1'b1, OFS_ECC_STORED, 32'hFFAB_CDEF);
        rdc(OFS_ECC_STORED, 32'h00AB_CDEF);
        chk({31'h0, err}, 32'h0);
        rdc(OFS_CLEAR, 32'h0);
        apb(1'b1, OFS_ENABLE, 32'h2);
        ecc(24'hABCDEF);
        rdc(OFS_STATUS, pins());
        ecc(24'hABCDEE);
        rdc(OFS_STATUS, pins() | 32'h2);
        apb(1'b1, OFS_CLEAR, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_ENABLE, 32'h0);
        ecc(24'h000001);
        rdc(OFS_STATUS, pins());
        apb(1'b0, 8'hC0, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule // tb
